/* File: swipr_bcast_throttle.sv */
// Purpose: per-port broadcast byte budget over one throttle interval
// Assumes: bcastByte pulses once per received broadcast byte, same clock
// Notes: overLimit tells the datapath to drop further broadcast bytes
module swipr_bcast_throttle
   import swipr_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic enable,
   input wire logic [BC_LVL_W-1:0] level,
   input wire logic intervalTick,
   input wire logic bcastByte,
   output logic overLimit
);

   logic [BC_CNT_W-1:0] count_r;
   logic [BC_CNT_W-1:0] count_nxt;
   logic overLimit_r;
   logic overLimit_nxt;
   logic [BC_CNT_W-1:0] limit;

   // level counts units of 64 bytes
   assign limit = {level, {BC_UNIT_SHIFT{1'b0}}};

   always_comb begin
      count_nxt = count_r;
      if (intervalTick) begin
         count_nxt = '0;
      end else if (bcastByte && (count_r < limit)) begin
         count_nxt = count_r + 14'h0001;
      end
      // throttling only acts while the port's enable is set
      overLimit_nxt = enable && (count_nxt >= limit); // R3 R4
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         count_r <= '0;
         overLimit_r <= 1'b0;
      end else begin
         count_r <= count_nxt;
         overLimit_r <= overLimit_nxt;
      end
   end

   assign overLimit = overLimit_r;

   throttle_gate_a : assert property (@(posedge clk) disable iff (!nrst) // R3
      !enable |=> !overLimit_r)
      else $error("throttle flagged with enable clear");

   throttle_budget_a : assert property (@(posedge clk) disable iff (!nrst) // R4
      (enable && $stable(enable) && $stable(level) && !intervalTick && (count_r + 14'h0001 < limit)) |=> !overLimit_r)
      else $error("throttle flagged before budget used");

endmodule : swipr_bcast_throttle

/* File: swipr_pkg.sv */
// Purpose: shared constants for the ingress policy register bank
// Assumes: register numbers are word indices on the switch register port
// Notes: all offsets, field positions, reset values and cycle counts live here
package swipr_pkg;

   // ---------------------------------------------------------------
   // register numbers
   // ---------------------------------------------------------------
   localparam logic [15:0] ADDR_TAG_FWD = 16'h1847;
   localparam logic [15:0] ADDR_BCAST = 16'h1848;
   localparam logic [15:0] ADDR_ADMIT = 16'h1849;
   localparam logic [15:0] ADDR_RATE_CFG = 16'h184a;
   localparam logic [15:0] ADDR_RATE_CMD = 16'h184b;
   localparam logic [15:0] ADDR_CMD_STS = 16'h184c;
   localparam logic [15:0] ADDR_WR_VAL = 16'h184d;
   localparam logic [15:0] ADDR_RD_VAL = 16'h184e;

   // ---------------------------------------------------------------
   // field layout
   // ---------------------------------------------------------------
   localparam int NUM_PORTS = 3;
   localparam int TAG_W = 6;
   localparam int TAG_FLD_W = 2;
   localparam logic [1:0] TAG_FWD_ON = 2'h3;
   localparam int BC_W = 27;
   localparam int BC_STRIDE = 9;
   localparam int BC_EN_OFS = 8;
   localparam int BC_LVL_W = 8;
   localparam int ADM_W = 3;
   localparam int CFG_W = 3;
   localparam int RATE_EN_BIT = 0;
   localparam int RATE_MODE_LSB = 1;
   localparam int CMD_W = 8;
   localparam int CMD_DIR_BIT = 7;
   localparam int CMD_TYPE_LSB = 5;
   localparam int CMD_ADDR_LSB = 0;
   localparam int TBL_W = 16;
   localparam int NUM_CIR = 24;

   localparam logic [1:0] MODE_PORT_PRI = 2'h0;
   localparam logic [1:0] MODE_PORT = 2'h1;
   localparam logic [1:0] MODE_PRI = 2'h2;
   localparam logic [1:0] MODE_RSVD = 2'h3;

   localparam logic [1:0] TYPE_RSVD = 2'h0;
   localparam logic [1:0] TYPE_CIR = 2'h1;
   localparam logic [1:0] TYPE_CBS = 2'h2;
   localparam logic [1:0] TYPE_EBS = 2'h3;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [TAG_W-1:0] RST_TAG = 6'h00;
   localparam logic [BC_W-1:0] RST_BCAST = 27'h0080402;
   localparam logic [ADM_W-1:0] RST_ADMIT = 3'h0;
   localparam logic [CFG_W-1:0] RST_CFG = 3'h0;
   localparam logic [CMD_W-1:0] RST_CMD = 8'h00;
   localparam logic [TBL_W-1:0] RST_CIR = 16'h0014;
   localparam logic [TBL_W-1:0] RST_BURST = 16'h0600;
   localparam logic [TBL_W-1:0] RST_WR_VAL = 16'h0000;

   // ---------------------------------------------------------------
   // broadcast throttle timing
   // ---------------------------------------------------------------
   localparam int BC_UNIT_SHIFT = 6;
   localparam int BC_CNT_W = 14;
   localparam int BC_TICK_W = 16;
   localparam real BC_INTERVAL_MS = 1.72;
   localparam real CLK_PERIOD_NS = 100.0;
   localparam int BC_INTERVAL_CYC = int'(BC_INTERVAL_MS * 1.0e6 / CLK_PERIOD_NS);

endpackage : swipr_pkg

/* File: swipr_policy_regs.sv */
// Purpose: ingress policy registers of a three-port switch engine
// Assumes: switch register port gives one-cycle read and write strobes
// Notes: read data appears one cycle after regRdEn with regRdValid
//
// Function
// R1 - port type 11b turns on tag forwarding
// R2 - port type fields 5:4, 3:2, 1:0
// R3 - per-port throttle enable bits 26, 17, 8
// R4 - level times 64 bytes per 1.72 ms
// R5 - levels at 25:18, 16:9, 7:0; enables reset 0
// R6 - admit bit accepts non-member port packets
// R7 - admit exception needs an active VLAN
// R8 - rate mode picks meter indexing; 11 reserved
// R9 - rate enable bit turns metering on
// R10 - command write starts one table access
// R11 - software reads data after pending clears
// R12 - software loads write data before command
// R13 - pending flag high while access runs
// R14 - command bit 7: 1 read, 0 write
// R15 - type field selects rate, burst, excess
// R16 - five-bit address selects one of 24
// R17 - port-priority mode: port times eight plus priority
// R18 - port-only mode: entry equals port
// R19 - priority-only mode: entry equals priority
// R20 - software keeps addresses in valid range
// R21 - committed rate entries reset to 0014h
// R22 - burst entries reset to 0600h
// R23 - reserved bits read zero, writes ignored
module swipr_policy_regs
   import swipr_pkg::*;
#(
   parameter int BC_INTERVAL_CYCLES = BC_INTERVAL_CYC
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [15:0] regAddr,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [31:0] regWrData,
   output logic [31:0] regRdData,
   output logic regRdValid,
   input wire logic pktValid,
   input wire logic [1:0] pktPort,
   input wire logic [2:0] pktPri,
   input wire logic pktPortMember,
   input wire logic pktVlanActive,
   input wire logic [NUM_PORTS-1:0] bcastByte,
   output logic [NUM_PORTS-1:0] tagForwardOn,
   output logic [NUM_PORTS-1:0] bcastDrop,
   output logic admitOk,
   output logic admitValid,
   output logic meteringOn,
   output logic [1:0] rateMode,
   output logic meterValid,
   output logic [4:0] meterIdx,
   output logic [TBL_W-1:0] meterCir,
   output logic [TBL_W-1:0] committedBurst,
   output logic [TBL_W-1:0] excessBurst
);

   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   logic [TAG_W-1:0] tagType_r, tagType_nxt;
   logic [BC_W-1:0] bcast_r, bcast_nxt;
   logic [ADM_W-1:0] admit_r, admit_nxt;
   logic [CFG_W-1:0] rateCfg_r, rateCfg_nxt;
   logic [CMD_W-1:0] cmd_r, cmd_nxt;
   logic [TBL_W-1:0] wrVal_r, wrVal_nxt;
   logic [31:0] rdData_r, rdData_nxt;
   logic rdValid_r, rdValid_nxt;

   logic tblPending;
   logic [TBL_W-1:0] tblRdValue;
   logic [TBL_W-1:0] lookCir;
   logic cmdStart;
   logic intervalTick;

   // a command written while one is still running is dropped whole,
   // so the running access never sees its fields change underneath it
   assign cmdStart = regWrEn && (regAddr == ADDR_RATE_CMD) && !tblPending; // R10

   always_comb begin
      tagType_nxt = tagType_r;
      bcast_nxt = bcast_r;
      admit_nxt = admit_r;
      rateCfg_nxt = rateCfg_r;
      cmd_nxt = cmd_r;
      wrVal_nxt = wrVal_r;
      if (regWrEn) begin
         // only defined bits are kept; reserved bits are dropped
         case (regAddr) // R23
            ADDR_TAG_FWD: tagType_nxt = regWrData[TAG_W-1:0]; // R2
            ADDR_BCAST: bcast_nxt = regWrData[BC_W-1:0]; // R5
            ADDR_ADMIT: admit_nxt = regWrData[ADM_W-1:0]; // R6
            ADDR_RATE_CFG: rateCfg_nxt = regWrData[CFG_W-1:0]; // R8
            ADDR_RATE_CMD: begin
               if (cmdStart) begin
                  cmd_nxt = regWrData[CMD_W-1:0];
               end
            end
            ADDR_WR_VAL: wrVal_nxt = regWrData[TBL_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         tagType_r <= RST_TAG; // R2
         bcast_r <= RST_BCAST; // R4 R5
         admit_r <= RST_ADMIT;
         rateCfg_r <= RST_CFG;
         cmd_r <= RST_CMD;
         wrVal_r <= RST_WR_VAL;
      end else begin
         tagType_r <= tagType_nxt;
         bcast_r <= bcast_nxt;
         admit_r <= admit_nxt;
         rateCfg_r <= rateCfg_nxt;
         cmd_r <= cmd_nxt;
         wrVal_r <= wrVal_nxt;
      end
   end

   // ---------------------------------------------------------------
   // register read
   // ---------------------------------------------------------------
   always_comb begin
      rdData_nxt = rdData_r;
      rdValid_nxt = regRdEn;
      if (regRdEn) begin
         rdData_nxt = 32'h00000000; // R23
         case (regAddr)
            ADDR_TAG_FWD: rdData_nxt[TAG_W-1:0] = tagType_r;
            ADDR_BCAST: rdData_nxt[BC_W-1:0] = bcast_r;
            ADDR_ADMIT: rdData_nxt[ADM_W-1:0] = admit_r;
            ADDR_RATE_CFG: rdData_nxt[CFG_W-1:0] = rateCfg_r;
            ADDR_RATE_CMD: rdData_nxt[CMD_W-1:0] = cmd_r;
            ADDR_CMD_STS: rdData_nxt[0] = tblPending; // R13
            ADDR_WR_VAL: rdData_nxt[TBL_W-1:0] = wrVal_r;
            ADDR_RD_VAL: rdData_nxt[TBL_W-1:0] = tblRdValue;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rdData_r <= 32'h00000000;
         rdValid_r <= 1'b0;
      end else begin
         rdData_r <= rdData_nxt;
         rdValid_r <= rdValid_nxt;
      end
   end

   assign regRdData = rdData_r;
   assign regRdValid = rdValid_r;

   // ---------------------------------------------------------------
   // metering table
   // ---------------------------------------------------------------
   logic [4:0] lookIdx;

   always_comb begin
      // out-of-range priority entries are software's responsibility
      case (rateCfg_r[RATE_MODE_LSB +: 2]) // R8
         MODE_PORT_PRI: lookIdx = {pktPort, pktPri}; // R17
         MODE_PORT: lookIdx = {3'h0, pktPort}; // R18
         MODE_PRI: lookIdx = {2'h0, pktPri}; // R19
         default: lookIdx = 5'h00;
      endcase
   end

   swipr_rate_table u_table (
      .clk(clk),
      .nrst(nrst),
      .start(cmdStart),
      .dirRead(regWrData[CMD_DIR_BIT]),
      .tblType(regWrData[CMD_TYPE_LSB +: 2]),
      .tblAddr(regWrData[CMD_ADDR_LSB +: 5]),
      .wrValue(wrVal_r),
      .lookIdx(lookIdx),
      .pending(tblPending),
      .rdValue(tblRdValue),
      .lookCir(lookCir),
      .cbs(committedBurst),
      .ebs(excessBurst)
   );

   logic meterOn_r, meterOn_nxt;
   logic [1:0] mode_r, mode_nxt;
   logic meterValid_r, meterValid_nxt;
   logic [4:0] meterIdx_r, meterIdx_nxt;
   logic [TBL_W-1:0] meterCir_r, meterCir_nxt;

   always_comb begin
      meterOn_nxt = rateCfg_r[RATE_EN_BIT]; // R9
      mode_nxt = rateCfg_r[RATE_MODE_LSB +: 2];
      meterValid_nxt = pktValid && rateCfg_r[RATE_EN_BIT] && (rateCfg_r[RATE_MODE_LSB +: 2] != MODE_RSVD); // R9
      meterIdx_nxt = meterIdx_r;
      meterCir_nxt = meterCir_r;
      if (pktValid) begin
         meterIdx_nxt = lookIdx;
         meterCir_nxt = lookCir;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         meterOn_r <= 1'b0;
         mode_r <= MODE_PORT_PRI;
         meterValid_r <= 1'b0;
         meterIdx_r <= 5'h00;
         meterCir_r <= RST_CIR;
      end else begin
         meterOn_r <= meterOn_nxt;
         mode_r <= mode_nxt;
         meterValid_r <= meterValid_nxt;
         meterIdx_r <= meterIdx_nxt;
         meterCir_r <= meterCir_nxt;
      end
   end

   assign meteringOn = meterOn_r;
   assign rateMode = mode_r;
   assign meterValid = meterValid_r;
   assign meterIdx = meterIdx_r;
   assign meterCir = meterCir_r;

   // ---------------------------------------------------------------
   // admission and tag forwarding
   // ---------------------------------------------------------------
   logic admitOk_r, admitOk_nxt;
   logic admitValid_r, admitValid_nxt;
   logic [NUM_PORTS-1:0] tagFwd_r, tagFwd_nxt;
   logic portAdmit;

   assign portAdmit = (pktPort < 2'(NUM_PORTS)) ? admit_r[pktPort] : 1'b0;

   always_comb begin
      admitValid_nxt = pktValid;
      admitOk_nxt = pktValid && pktVlanActive && (pktPortMember || portAdmit); // R6 R7
   end

   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      assign tagFwd_nxt[p] = (tagType_r[TAG_FLD_W*p +: TAG_FLD_W] == TAG_FWD_ON); // R1

      swipr_bcast_throttle u_throttle (
         .clk(clk),
         .nrst(nrst),
         .enable(bcast_r[BC_STRIDE*p + BC_EN_OFS]), // R3
         .level(bcast_r[BC_STRIDE*p +: BC_LVL_W]), // R5
         .intervalTick(intervalTick),
         .bcastByte(bcastByte[p]),
         .overLimit(bcastDrop[p])
      );
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         admitOk_r <= 1'b0;
         admitValid_r <= 1'b0;
         tagFwd_r <= '0;
      end else begin
         admitOk_r <= admitOk_nxt;
         admitValid_r <= admitValid_nxt;
         tagFwd_r <= tagFwd_nxt;
      end
   end

   assign admitOk = admitOk_r;
   assign admitValid = admitValid_r;
   assign tagForwardOn = tagFwd_r;

   // ---------------------------------------------------------------
   // throttle interval timer
   // ---------------------------------------------------------------
   logic [BC_TICK_W-1:0] tickCnt_r, tickCnt_nxt;

   // one shared timer keeps every port's interval aligned
   assign intervalTick = (tickCnt_r == BC_TICK_W'(BC_INTERVAL_CYCLES - 1)); // R4

   always_comb begin
      tickCnt_nxt = intervalTick ? '0 : tickCnt_r + 16'h0001;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         tickCnt_r <= '0;
      end else begin
         tickCnt_r <= tickCnt_nxt;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence tagWrite_s;
      regWrEn && (regAddr == ADDR_TAG_FWD) && (regWrData[5:4] == 2'h3);
   endsequence

   tag_forward_a : assert property (@(posedge clk) disable iff (!nrst) // R1
      tagWrite_s |=> ##1 tagFwd_r[2])
      else $error("port 2 tag forwarding not on after 11b");

   admit_active_a : assert property (@(posedge clk) disable iff (!nrst) // R7
      (pktValid && !pktVlanActive) |=> (admitValid_r && !admitOk_r))
      else $error("packet admitted to inactive vlan");

   admit_member_a : assert property (@(posedge clk) disable iff (!nrst) // R6
      (pktValid && pktVlanActive && pktPort == 2'h1 && admit_r[1]) |=> admitOk_r)
      else $error("admit bit ignored");

   port_index_a : assert property (@(posedge clk) disable iff (!nrst) // R18
      (pktValid && rateCfg_r[2:1] == MODE_PORT && pktPort == 2'h2) |=> (meterIdx_r == 5'h02))
      else $error("port only index wrong");

   prio_port_index_a : assert property (@(posedge clk) disable iff (!nrst) // R17
      (pktValid && rateCfg_r[2:1] == MODE_PORT_PRI && pktPort == 2'h2 && pktPri == 3'h3) |=> (meterIdx_r == 5'h13))
      else $error("port priority index wrong");

   reserved_zero_a : assert property (@(posedge clk) disable iff (!nrst) // R23
      (regRdEn && regAddr == ADDR_BCAST) |=> (regRdValid && regRdData[31:27] == 5'h00))
      else $error("reserved bits read nonzero");

   status_busy_a : assert property (@(posedge clk) disable iff (!nrst) // R13
      (cmdStart ##1 (regRdEn && regAddr == ADDR_CMD_STS)) |=> regRdData[0])
      else $error("status not pending after command");

   interval_tick_a : assert property (@(posedge clk) disable iff (!nrst) // R4
      intervalTick |=> (tickCnt_r == 16'h0000) ##1 !intervalTick)
      else $error("interval timer did not wrap");

   cmd_locked_a : assert property (@(posedge clk) disable iff (!nrst) // R10
      (regWrEn && regAddr == ADDR_RATE_CMD && tblPending) |=> (cmd_r == $past(cmd_r)))
      else $error("command taken while pending");

   metering_off_a : assert property (@(posedge clk) disable iff (!nrst) // R9
      (pktValid && !rateCfg_r[RATE_EN_BIT]) |=> !meterValid_r)
      else $error("meter valid with metering off");

endmodule : swipr_policy_regs

/* File: swipr_rate_table.sv */
// Purpose: metering table (24 committed rate entries, two burst sizes)
// Assumes: start only arrives while pending is low
// Notes: every access takes one cycle in the access state
module swipr_rate_table
   import swipr_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic start,
   input wire logic dirRead,
   input wire logic [1:0] tblType,
   input wire logic [4:0] tblAddr,
   input wire logic [TBL_W-1:0] wrValue,
   input wire logic [4:0] lookIdx,
   output logic pending,
   output logic [TBL_W-1:0] rdValue,
   output logic [TBL_W-1:0] lookCir,
   output logic [TBL_W-1:0] cbs,
   output logic [TBL_W-1:0] ebs
);

   typedef enum logic {TBL_IDLE, TBL_ACCESS} swipr_tbl_state_t;

   swipr_tbl_state_t state_r;
   swipr_tbl_state_t state_nxt;
   logic dir_r, dir_nxt;
   logic [1:0] type_r, type_nxt;
   logic [4:0] addr_r, addr_nxt;
   logic [TBL_W-1:0] val_r, val_nxt;
   logic [TBL_W-1:0] rd_r, rd_nxt;
   logic [TBL_W-1:0] cbs_r, cbs_nxt;
   logic [TBL_W-1:0] ebs_r, ebs_nxt;
   logic [TBL_W-1:0] cir_r [NUM_CIR];
   logic wrCir;
   logic [TBL_W-1:0] cirAtAddr;

   // out-of-range committed rate addresses read zero and write nothing
   assign cirAtAddr = (addr_r < 5'(NUM_CIR)) ? cir_r[addr_r] : '0; // R16
   assign lookCir = (lookIdx < 5'(NUM_CIR)) ? cir_r[lookIdx] : '0;
   assign wrCir = (state_r == TBL_ACCESS) && !dir_r && (type_r == TYPE_CIR);

   always_comb begin
      state_nxt = state_r;
      dir_nxt = dir_r;
      type_nxt = type_r;
      addr_nxt = addr_r;
      val_nxt = val_r;
      rd_nxt = rd_r;
      cbs_nxt = cbs_r;
      ebs_nxt = ebs_r;
      case (state_r)
         TBL_IDLE: begin
            if (start) begin
               state_nxt = TBL_ACCESS; // R10
               dir_nxt = dirRead;
               type_nxt = tblType;
               addr_nxt = tblAddr;
               val_nxt = wrValue;
            end
         end
         TBL_ACCESS: begin
            state_nxt = TBL_IDLE;
            if (dir_r) begin // R14
               case (type_r) // R15
                  TYPE_CIR: rd_nxt = cirAtAddr;
                  TYPE_CBS: rd_nxt = cbs_r;
                  TYPE_EBS: rd_nxt = ebs_r;
                  default: rd_nxt = '0;
               endcase
            end else begin
               case (type_r) // R15
                  TYPE_CBS: cbs_nxt = val_r;
                  TYPE_EBS: ebs_nxt = val_r;
                  default: ;
               endcase
            end
         end
         default: state_nxt = TBL_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_r <= TBL_IDLE;
         dir_r <= 1'b0;
         type_r <= TYPE_RSVD;
         addr_r <= '0;
         val_r <= '0;
         rd_r <= '0;
         cbs_r <= RST_BURST; // R22
         ebs_r <= RST_BURST; // R22
      end else begin
         state_r <= state_nxt;
         dir_r <= dir_nxt;
         type_r <= type_nxt;
         addr_r <= addr_nxt;
         val_r <= val_nxt;
         rd_r <= rd_nxt;
         cbs_r <= cbs_nxt;
         ebs_r <= ebs_nxt;
      end
   end

   // ---------------------------------------------------------------
   // committed rate entries
   // ---------------------------------------------------------------
   for (genvar i = 0; i < NUM_CIR; i++) begin : g_cir
      logic [TBL_W-1:0] cirNxt;
      always_comb begin
         cirNxt = cir_r[i];
         if (wrCir && (addr_r == 5'(i))) begin
            cirNxt = val_r;
         end
      end
      always_ff @(posedge clk) begin
         if (!nrst) begin
            cir_r[i] <= RST_CIR; // R21
         end else begin
            cir_r[i] <= cirNxt;
         end
      end
   end

   assign pending = (state_r == TBL_ACCESS); // R13
   assign rdValue = rd_r;
   assign cbs = cbs_r;
   assign ebs = ebs_r;

   sequence startIdle_s;
      start && (state_r == TBL_IDLE);
   endsequence

   sequence busyThenDone_s;
      pending ##1 !pending;
   endsequence

   pending_pulse_a : assert property (@(posedge clk) disable iff (!nrst) // R13
      startIdle_s |=> busyThenDone_s)
      else $error("pending flag not one access long");

   cir_write_a : assert property (@(posedge clk) disable iff (!nrst) // R10
      (startIdle_s ##0 (!dirRead && tblType == TYPE_CIR && tblAddr == 5'h05)) |=> ##1 (cir_r[5] == $past(wrValue, 2)))
      else $error("committed rate entry not written");

   burst_read_a : assert property (@(posedge clk) disable iff (!nrst) // R14
      (startIdle_s ##0 (dirRead && tblType == TYPE_EBS)) |=> ##1 (rd_r == ebs_r))
      else $error("excess burst read returned wrong value");

   burst_reset_a : assert property (@(posedge clk) // R22
      $rose(nrst) |-> (cbs_r == RST_BURST) && (ebs_r == RST_BURST) && (cir_r[0] == RST_CIR))
      else $error("table reset values wrong");

endmodule : swipr_rate_table

/* File: swipr_tb.sv */
// Purpose: self-checking bench for the ingress policy register bank
// Assumes: inputs change at the falling edge, interval shortened to 256 cycles
// Notes: a 140-cycle byte burst always holds one full 64-byte budget between ticks
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import swipr_pkg::*;
   logic clk = 0, nrst = 0, regWrEn = 0, regRdEn = 0, regRdValid, pktValid = 0, pktPortMember = 0;
   logic pktVlanActive = 0, admitOk, admitValid, meteringOn, meterValid;
   logic [15:0] regAddr = 0, meterCir, committedBurst, excessBurst;
   logic [31:0] regWrData = 0, regRdData, d;
   logic [1:0] pktPort = 0, rateMode;
   logic [2:0] pktPri = 0, bcastByte = 0, tagForwardOn, bcastDrop;
   logic [4:0] meterIdx;
   logic [79:0] rows [6] = '{{16'h1847, 32'hffffffff, 32'h3f}, {16'h1848, 32'hffffffff, 32'h7ffffff},
      {16'h1849, 32'hffffffff, 32'h7}, {16'h184a, 32'hffffffff, 32'h7}, {16'h184d, 32'hffffffff, 32'hffff},
      {16'h1850, 32'hffffffff, 32'h0}};
   int miscompares = 0, testsRun = 0;
   always #50 clk = ~clk;
   swipr_policy_regs #(.BC_INTERVAL_CYCLES(256)) dut (.clk(clk), .nrst(nrst), .regAddr(regAddr),
      .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
      .regRdValid(regRdValid), .pktValid(pktValid), .pktPort(pktPort), .pktPri(pktPri),
      .pktPortMember(pktPortMember), .pktVlanActive(pktVlanActive), .bcastByte(bcastByte),
      .tagForwardOn(tagForwardOn), .bcastDrop(bcastDrop), .admitOk(admitOk), .admitValid(admitValid),
      .meteringOn(meteringOn), .rateMode(rateMode), .meterValid(meterValid), .meterIdx(meterIdx),
      .meterCir(meterCir), .committedBurst(committedBurst), .excessBurst(excessBurst));
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      testsRun++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task give_verdict;
      $display("comparisons %0d mismatches %0d", testsRun, miscompares);
      if (miscompares == 0 && testsRun > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : give_verdict
   task wr(input logic [15:0] a, input logic [31:0] v);
      regAddr = a; regWrData = v; regWrEn = 1;
      @(negedge clk) regWrEn = 0;
      @(negedge clk);
   endtask : wr
   task rd(input logic [15:0] a, input logic [31:0] e, input string n);
      regAddr = a; regRdEn = 1;
      @(negedge clk) regRdEn = 0;
      chk("read valid", 1, regRdValid);
      chk(n, e, regRdData);
      @(negedge clk);
   endtask : rd
   // table access: command, then poll the pending flag with a bound
   task tbl(input logic [7:0] c);
      wr(16'h184b, {24'h0, c});
      for (int i = 0; i < 9; i++) begin
         regAddr = 16'h184c; regRdEn = 1;
         @(negedge clk) regRdEn = 0;
         d = regRdData;
         @(negedge clk);
         if (d[0] === 1'b0) return;
      end
      chk("pending timeout", 0, 1);
      give_verdict();
   endtask : tbl
   task pkt(input logic [1:0] p, input logic [2:0] q, input logic m, input logic v, input logic [6:0] e);
      pktPort = p; pktPri = q; pktPortMember = m; pktVlanActive = v; pktValid = 1;
      @(negedge clk) pktValid = 0;
      chk("admit", {e[6], 1'b1}, {admitOk, admitValid});
      chk("meter valid", e[5], meterValid);
      if (e[5]) chk("meter index", e[4:0], meterIdx);
      @(negedge clk);
   endtask : pkt
   task rstchk;
      nrst = 0;
      repeat (8) @(negedge clk);
      nrst = 1;
      rd(16'h1847, 0, "type reset");
      rd(16'h1848, 32'h0080402, "throttle reset");
      chk("bursts reset", 32'h06000600, {committedBurst, excessBurst});
      chk("outputs reset", 0, {tagForwardOn, bcastDrop, meteringOn});
      $display("reset test done");
   endtask : rstchk
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      @(negedge clk);
      rstchk();
      tbl(8'ha5);
      rd(16'h184e, 32'h0014, "entry reset");
      foreach (rows[i]) begin
         wr(rows[i][79:64], rows[i][63:32]);
         rd(rows[i][79:64], rows[i][31:0], "row readback");
      end
      $display("register rows done");
      wr(16'h1847, 32'h39);
      chk("tag forward", 3'h4, tagForwardOn);
      wr(16'h184d, 32'habcd);
      tbl(8'h25);
      tbl(8'ha5);
      rd(16'h184e, 32'habcd, "entry readback");
      tbl(8'h45);
      tbl(8'h65);
      chk("bursts", 32'habcdabcd, {committedBurst, excessBurst});
      tbl(8'h85);
      rd(16'h184e, 0, "reserved type");
      // status read and a second command while the first is still pending
      regAddr = 16'h184b; regWrData = 32'he5; regWrEn = 1;
      @(negedge clk) regWrEn = 0;
      regAddr = 16'h184c; regRdEn = 1;
      @(negedge clk) regRdEn = 0;
      chk("pending busy", 1, regRdData);
      rd(16'h184e, 32'habcd, "excess readback");
      wr(16'h184d, 32'h1234);
      regAddr = 16'h184b; regWrData = 32'h45; regWrEn = 1;
      @(negedge clk) regWrData = 32'h25;
      @(negedge clk) regWrEn = 0;
      rd(16'h184b, 32'h45, "locked command");
      chk("burst write", 32'h1234, committedBurst);
      tbl(8'ha5);
      rd(16'h184e, 32'habcd, "locked entry");
      $display("table test done");
      wr(16'h1849, 32'h2);
      wr(16'h184a, 32'h1);
      pkt(2, 3, 0, 1, 7'h33);
      pkt(1, 0, 0, 0, 7'h28);
      pkt(0, 0, 0, 1, 7'h20);
      wr(16'h184a, 32'h3);
      pkt(2, 3, 1, 1, 7'h62);
      wr(16'h184a, 32'h5);
      chk("rate config", 3'h5, {rateMode, meteringOn});
      pkt(1, 5, 0, 1, 7'h65);
      chk("meter rate", 32'habcd, meterCir);
      wr(16'h184a, 32'h7);
      pkt(0, 1, 1, 1, 7'h40);
      wr(16'h184a, 32'h4);
      chk("rate config", 3'h4, {rateMode, meteringOn});
      pkt(0, 1, 1, 1, 7'h40);
      $display("lookup test done");
      wr(16'h1848, 32'h4040100);
      chk("bcast start", 3'h1, bcastDrop);
      d = 0;
      for (int i = 0; i < 140; i++) begin
         bcastByte = 3'h6;
         @(negedge clk);
         d = d | {29'h0, bcastDrop};
      end
      bcastByte = 0;
      chk("bcast drops", 32'h5, d);
      $display("throttle test done");
      rstchk();
      give_verdict();
   end
endmodule : tb
